// [inc/watchdog_pkg.sv]
package watchdog_pkg;

    // ----------------------------------------
    // Register map (index, byte address)
    // ----------------------------------------
    localparam logic [7:0] KEY_IDX = 8'h00;
    localparam logic [7:0] PRESC_IDX = 8'h01;
    localparam logic [7:0] RELOAD_IDX = 8'h02;
    localparam logic [7:0] STATUS_IDX = 8'h03;
    localparam logic [7:0] KEY_ADDR = KEY_IDX << 2;
    localparam logic [7:0] PRESC_ADDR = PRESC_IDX << 2;
    localparam logic [7:0] RELOAD_ADDR = RELOAD_IDX << 2;
    localparam logic [7:0] STATUS_ADDR = STATUS_IDX << 2;

    // ----------------------------------------
    // Key codes
    // ----------------------------------------
    localparam logic [7:0] KEY_START = 8'hcc;
    localparam logic [7:0] KEY_REFRESH = 8'haa;
    localparam logic [7:0] KEY_UNLOCK = 8'h55;

    // ----------------------------------------
    // Reset values and field layout
    // ----------------------------------------
    localparam logic [7:0] COUNT_START = 8'hff;
    localparam logic [7:0] RELOAD_RST = 8'hff;
    localparam logic [2:0] PRESC_RST = 3'h0;
    localparam logic [2:0] PRESC_MAX = 3'h6;
    localparam logic [2:0] PRESC_RSVD = 3'h7;
    localparam logic [9:0] PRESC_BASE = 10'h008;
    localparam int STATUS_RUN_BIT = 0;
    localparam int STATUS_UNLOCK_BIT = 1;
    localparam int STATUS_GRACE_BIT = 2;
    localparam int STATUS_FIRE_BIT = 3;
    localparam int STATUS_COUNT_LSB = 8;

    // ----------------------------------------
    // Timing: grace in low-speed clock periods, strap settle in clk cycles
    // ----------------------------------------
    localparam logic [2:0] GRACE_TICKS = 3'h6;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // Watchdog states, Gray coded along idle-run-grace-fire
    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_RUN = 2'b01,
        WD_GRACE = 2'b11,
        WD_FIRE = 2'b10
    } wd_state_t;

endpackage

// [core/lsi_edge_detect.sv]
module lsi_edge_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Low-speed oscillator pin
    input wire logic lsi_clk,
    // One-cycle pulse per oscillator rising edge
    output logic tick
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic tick;
    } edge_state_t;

    edge_state_t r_reg;
    edge_state_t r_next;

    // Two-flop synchroniser, edge taken only between second and third stage
    always_comb begin
        r_next = r_reg;
        r_next.s1 = lsi_clk;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        r_next.tick = r_reg.s2 & ~r_reg.s3;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tick = r_reg.tick;

endmodule

// [core/independent_watchdog.sv]
// Operation
// - Start key launches the countdown from 0xff.
// - Counter at zero leads to system reset request.
// - Refresh key reloads the counter from the reload value.
// - Prescale and reload registers ignore writes until unlock key.
// - Refresh key after unlock relocks the registers and refreshes.
// - Hardware start option starts the watchdog after reset.
// - Counting steps on low-speed oscillator edges sampled in the main clock, so it needs the main clock.
// - Timeout is two oscillator periods times divisor times reload plus one.
// - Reset fires six oscillator periods after the nominal timeout.
// - Divisor select codes 0 to 6 give divide by 4 to 256.
// - Reload resets to 0xff, prescale select resets to zero.
module independent_watchdog (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator and option strap
    input wire logic low_speed_internal_oscillator,
    input wire logic hardware_start_option,
    // Reset request to the system
    output logic system_reset_req
);
    import watchdog_pkg::*;

    typedef struct packed {
        wd_state_t state;
        logic unlocked;
        logic [2:0] pr_shadow;
        logic [7:0] rl_shadow;
        logic [2:0] pr_act;
        logic [7:0] rl_act;
        logic [7:0] count;
        logic [9:0] pre_cnt;
        logic [2:0] grace_cnt;
        logic strap_s1;
        logic strap_s2;
        logic [1:0] strap_wait;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic wdg_rst;
    } wd_regs_t;

    wd_regs_t r_reg;
    wd_regs_t r_next;
    logic tick;
    logic wr_access;
    logic key_wr;
    logic start_key;
    logic refresh_key;
    logic unlock_key;
    logic last_pre;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Last prescale count: two times divisor minus one, reserved code clamped to max
    function automatic logic [9:0] period_last(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel == PRESC_RSVD) ? PRESC_MAX : sel;
        return (PRESC_BASE << s) - 10'h001;
    endfunction

    // ----------------------------------------
    // Oscillator edge detection
    // ----------------------------------------
    // Sampled in the bus clock; a dead main clock also halts the bus,
    // so the request reg is held for the system reset to act on
    lsi_edge_detect u_lsi_edge (
        .clk(clk),
        .rst_n(rst_n),
        .lsi_clk(low_speed_internal_oscillator),
        .tick(tick)
    );

    // Bus access decode, writes land on the access edge only
    assign wr_access = psel & penable & r_reg.pready & pwrite;
    assign key_wr = wr_access && (paddr == KEY_ADDR);
    assign start_key = key_wr && (pwdata[7:0] == KEY_START);
    assign refresh_key = key_wr && (pwdata[7:0] == KEY_REFRESH);
    assign unlock_key = key_wr && (pwdata[7:0] == KEY_UNLOCK);
    // At or past the last count, so a divisor lowered mid-step ends the step
    // at once instead of waiting for the prescale counter to wrap
    assign last_pre = (r_reg.pre_cnt >= period_last(r_reg.pr_act));

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        r_next = r_reg;

        // Zero-wait APB: answer prepared in setup, shown in access
        r_next.pready = psel & ~penable;
        r_next.pslverr = 1'b0;
        r_next.prdata = 32'h00000000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                KEY_ADDR: r_next.prdata = 32'h00000000;
                PRESC_ADDR: r_next.prdata = {29'h0, r_reg.pr_shadow};
                RELOAD_ADDR: r_next.prdata = {24'h0, r_reg.rl_shadow};
                STATUS_ADDR: begin
                    r_next.prdata[STATUS_RUN_BIT] = (r_reg.state != WD_IDLE);
                    r_next.prdata[STATUS_UNLOCK_BIT] = r_reg.unlocked;
                    r_next.prdata[STATUS_GRACE_BIT] = (r_reg.state == WD_GRACE);
                    r_next.prdata[STATUS_FIRE_BIT] = (r_reg.state == WD_FIRE);
                    r_next.prdata[STATUS_COUNT_LSB +: 8] = r_reg.count;
                end
                default: r_next.pslverr = 1'b1;
            endcase
        end else if (psel && !penable) begin
            // Writes to status or unmapped space are refused
            r_next.pslverr = (paddr != KEY_ADDR) && (paddr != PRESC_ADDR) && (paddr != RELOAD_ADDR);
        end

        // Protected registers take writes only while unlocked
        if (wr_access && r_reg.unlocked && paddr == PRESC_ADDR) begin
            r_next.pr_shadow = pwdata[2:0];
        end
        if (wr_access && r_reg.unlocked && paddr == RELOAD_ADDR) begin
            r_next.rl_shadow = pwdata[7:0];
        end
        if (unlock_key) begin
            r_next.unlocked = 1'b1;
        end

        // Settings move to the counting side only on an oscillator tick,
        // so they change between prescale counts, never inside one
        if (tick) begin
            r_next.pr_act = r_reg.pr_shadow;
            r_next.rl_act = r_reg.rl_shadow;
        end

        // Strap synchroniser, option caught once after reset release
        r_next.strap_s1 = hardware_start_option;
        r_next.strap_s2 = r_reg.strap_s1;
        if (r_reg.strap_wait != STRAP_SETTLE) begin
            r_next.strap_wait = r_reg.strap_wait + 2'h1;
        end

        // Watchdog sequencing; other key values fall through untouched
        unique case (r_reg.state)
            WD_IDLE: begin
                if (start_key) begin
                    r_next.state = WD_RUN;
                    r_next.count = COUNT_START;
                    r_next.pre_cnt = 10'h000;
                end else if (r_reg.strap_wait == STRAP_SETTLE - 2'h1 && r_reg.strap_s2) begin
                    r_next.state = WD_RUN;
                    r_next.count = COUNT_START;
                    r_next.pre_cnt = 10'h000;
                end
            end
            WD_RUN: begin
                // One decrement per two oscillator periods times divisor
                if (refresh_key) begin
                    r_next.count = r_reg.rl_act;
                    r_next.pre_cnt = 10'h000;
                end else if (tick && last_pre) begin
                    r_next.pre_cnt = 10'h000;
                    if (r_reg.count == 8'h00) begin
                        r_next.state = WD_GRACE;
                        r_next.grace_cnt = 3'h0;
                    end else begin
                        r_next.count = r_reg.count - 8'h01;
                    end
                end else if (tick) begin
                    r_next.pre_cnt = r_reg.pre_cnt + 10'h001;
                end
            end
            WD_GRACE: begin
                // A late refresh still rescues the system here
                if (refresh_key) begin
                    r_next.state = WD_RUN;
                    r_next.count = r_reg.rl_act;
                    r_next.pre_cnt = 10'h000;
                end else if (tick) begin
                    r_next.grace_cnt = r_reg.grace_cnt + 3'h1;
                    if (r_reg.grace_cnt == GRACE_TICKS - 3'h1) begin
                        r_next.state = WD_FIRE;
                        r_next.wdg_rst = 1'b1;
                    end
                end
            end
            WD_FIRE: begin
                // Held until the system reset comes back as rst_n
                r_next.wdg_rst = 1'b1;
            end
        endcase

        // Refresh always relocks, running or not
        if (refresh_key) begin
            r_next.unlocked = 1'b0;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= '0;
            r_reg.state <= WD_IDLE;
            r_reg.pr_shadow <= PRESC_RST;
            r_reg.rl_shadow <= RELOAD_RST;
            r_reg.pr_act <= PRESC_RST;
            r_reg.rl_act <= RELOAD_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign system_reset_req = r_reg.wdg_rst;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Building blocks for the multi-step properties
    sequence s_key(logic [7:0] v);
        key_wr && pwdata[7:0] == v;
    endsequence

    sequence s_other_key;
        key_wr && pwdata[7:0] != KEY_START && pwdata[7:0] != KEY_REFRESH && pwdata[7:0] != KEY_UNLOCK;
    endsequence

    sequence s_final_step;
        r_reg.state == WD_RUN && tick && last_pre && !refresh_key;
    endsequence

    sequence s_grace_tick;
        r_reg.state == WD_GRACE && tick && !refresh_key;
    endsequence

    // Starting: only the start key or the strap leaves idle,
    // and nothing but a system reset brings the watchdog back
    a_start_load: assert property (s_key(KEY_START) and r_reg.state == WD_IDLE
        |=> r_reg.state == WD_RUN && r_reg.count == COUNT_START)
        else $error("start key did not launch countdown");

    a_idle_wait: assert property (r_reg.state == WD_IDLE && r_reg.strap_wait == STRAP_SETTLE
        && !start_key |=> r_reg.state == WD_IDLE)
        else $error("watchdog left idle without start key");

    a_hw_start: assert property (r_reg.state == WD_IDLE && r_reg.strap_s2 && !start_key
        && r_reg.strap_wait == STRAP_SETTLE - 2'h1 |=> r_reg.state == WD_RUN && r_reg.count == COUNT_START)
        else $error("strap did not start the watchdog");

    a_stray_key: assert property (s_other_key and r_reg.state == WD_IDLE
        and r_reg.strap_wait == STRAP_SETTLE |=> r_reg.state == WD_IDLE && $stable(r_reg.unlocked))
        else $error("undefined key had an effect");

    a_no_stop: assert property (r_reg.state != WD_IDLE |=> r_reg.state != WD_IDLE)
        else $error("running watchdog stopped");

    // Countdown: prescale steps, decrements and the end of count
    a_step_count: assert property (r_reg.state == WD_RUN && tick && !refresh_key && !last_pre
        |=> r_reg.pre_cnt == $past(r_reg.pre_cnt) + 10'h001)
        else $error("prescale count skipped");

    a_step_end: assert property (s_final_step |=> r_reg.pre_cnt == 10'h000)
        else $error("prescale step did not wrap");

    a_decrement: assert property (s_final_step and r_reg.count != 8'h00
        |=> r_reg.count == $past(r_reg.count) - 8'h01)
        else $error("counter step wrong");

    a_zero_grace: assert property (s_final_step and r_reg.count == 8'h00
        |=> r_reg.state == WD_GRACE && r_reg.grace_cnt == 3'h0)
        else $error("zero count did not enter grace");

    // Keys and protected settings; a slow copy on the counting side
    // is the price of never changing a divisor mid-count
    a_refresh_load: assert property (s_key(KEY_REFRESH) and r_reg.state != WD_IDLE
        and r_reg.state != WD_FIRE |=> r_reg.count == $past(r_reg.rl_act)
        && r_reg.pre_cnt == 10'h000 && r_reg.state == WD_RUN)
        else $error("refresh did not reload counter");

    a_refresh_lock: assert property (s_key(KEY_REFRESH) and r_reg.unlocked
        |=> !r_reg.unlocked)
        else $error("refresh did not relock");

    a_unlock_set: assert property (s_key(KEY_UNLOCK) |=> r_reg.unlocked)
        else $error("unlock key did not open registers");

    a_locked_hold: assert property (wr_access && !r_reg.unlocked && paddr == RELOAD_ADDR
        |=> $stable(r_reg.rl_shadow))
        else $error("locked reload register changed");

    a_locked_presc: assert property (wr_access && !r_reg.unlocked && paddr == PRESC_ADDR
        |=> $stable(r_reg.pr_shadow))
        else $error("locked prescale register changed");

    a_unlocked_write: assert property (wr_access && r_reg.unlocked && paddr == RELOAD_ADDR
        |=> r_reg.rl_shadow == $past(pwdata[7:0]))
        else $error("unlocked reload write lost");

    a_shadow_copy: assert property (tick |=> r_reg.pr_act == $past(r_reg.pr_shadow)
        && r_reg.rl_act == $past(r_reg.rl_shadow))
        else $error("settings not moved on tick");

    a_settle_sync: assert property (!tick && r_reg.state == WD_RUN |=> $stable(r_reg.rl_act))
        else $error("reload copy changed off tick");

    // Grace countdown and the reset request, which is a level
    // held until the system reset comes back
    a_grace_step: assert property (s_grace_tick and r_reg.grace_cnt != GRACE_TICKS - 3'h1
        |=> r_reg.state == WD_GRACE && r_reg.grace_cnt == $past(r_reg.grace_cnt) + 3'h1)
        else $error("grace count skipped");

    a_grace_fire: assert property (s_grace_tick and r_reg.grace_cnt == GRACE_TICKS - 3'h1
        |=> system_reset_req ##1 system_reset_req)
        else $error("reset not raised after grace");

    a_grace_bound: assert property (r_reg.state == WD_GRACE |-> r_reg.grace_cnt < GRACE_TICKS)
        else $error("grace count overran");

    a_fire_hold: assert property (r_reg.state == WD_FIRE |=> r_reg.state == WD_FIRE && system_reset_req)
        else $error("reset request dropped");

    a_reset_cause: assert property ($rose(system_reset_req) |-> r_reg.state == WD_FIRE
        && $past(r_reg.state) == WD_GRACE)
        else $error("reset raised outside grace end");

    a_quiet_reset: assert property (r_reg.state != WD_FIRE |-> !system_reset_req)
        else $error("reset requested while not fired");

endmodule

// [verif/independent_watchdog_tb.sv]
module independent_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import watchdog_pkg::*;

    // ----------------------------------------
    // Stimulus, results and design
    // ----------------------------------------
    localparam int RL = 3;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic osc = 1'b0;
    logic strap = 1'b0;
    logic system_reset_req;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int check_count = 0;

    independent_watchdog DUT (
        .clk(clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .low_speed_internal_oscillator(osc),
        .hardware_start_option(strap),
        .system_reset_req(system_reset_req)
    );

    // 40 MHz main clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    // Oscillator sped up to 8 clk periods to keep timeouts short;
    // the design still takes it through its own two-flop synchroniser
    initial begin
        forever begin
            repeat (4) @(posedge clk);
            osc <= ~osc;
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk_bit("pready", 1'b1, pready);
    endtask

    task automatic rdreg(input logic [7:0] addr, input logic [31:0] exp, input string name);
        apb(1'b0, addr, 32'h00000000);
        chk_word(name, exp, rd);
        chk_bit("read_no_error", 1'b0, err);
    endtask

    task automatic do_reset(input logic opt);
        rst_n <= 1'b0;
        strap <= opt;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic results;
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_values;
        rdreg(PRESC_ADDR, 32'h00000000, "prescale_reset");
        rdreg(RELOAD_ADDR, 32'h000000ff, "reload_reset");
        rdreg(KEY_ADDR, 32'h00000000, "key_read");
        apb(1'b0, 8'h10, 32'h00000000);
        chk_bit("unmapped_err", 1'b1, err);
        apb(1'b1, STATUS_ADDR, 32'h000000ff);
        chk_bit("status_write_err", 1'b1, err);
    endtask

    task automatic t_lock;
        apb(1'b1, KEY_ADDR, 32'h00000012);
        apb(1'b1, RELOAD_ADDR, 32'h00000003);
        rdreg(RELOAD_ADDR, 32'h000000ff, "reload_locked");
        apb(1'b0, STATUS_ADDR, 32'h00000000);
        chk_bit("idle_after_bad_key", 1'b0, rd[STATUS_RUN_BIT]);
        apb(1'b1, KEY_ADDR, {24'h000000, KEY_UNLOCK});
        apb(1'b0, STATUS_ADDR, 32'h00000000);
        chk_bit("unlocked", 1'b1, rd[STATUS_UNLOCK_BIT]);
        for (int pr = 0; pr <= 7; pr++) begin
            apb(1'b1, PRESC_ADDR, pr);
            rdreg(PRESC_ADDR, pr, "prescale_code");
        end
        apb(1'b1, PRESC_ADDR, 32'h00000000);
        apb(1'b1, RELOAD_ADDR, RL);
        rdreg(RELOAD_ADDR, RL, "reload_written");
        apb(1'b1, KEY_ADDR, {24'h000000, KEY_REFRESH});
        apb(1'b0, STATUS_ADDR, 32'h00000000);
        chk_bit("relocked", 1'b0, rd[STATUS_UNLOCK_BIT]);
        apb(1'b1, RELOAD_ADDR, 32'h00000005);
        rdreg(RELOAD_ADDR, RL, "reload_relocked");
        apb(1'b1, PRESC_ADDR, 32'h00000005);
        rdreg(PRESC_ADDR, 32'h00000000, "prescale_relocked");
    endtask

    // New reload reaches the counting side only at an oscillator tick
    task automatic t_start;
        repeat (40) @(posedge clk);
        apb(1'b1, KEY_ADDR, {24'h000000, KEY_START});
        apb(1'b0, STATUS_ADDR, 32'h00000000);
        chk_bit("running", 1'b1, rd[STATUS_RUN_BIT]);
        chk_word("start_count", 32'h000000ff, {24'h000000, rd[15:8]});
    endtask

    // Refresh well inside the 304-cycle timeout
    task automatic t_refresh;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, KEY_ADDR, {24'h000000, KEY_REFRESH});
            repeat (200) @(posedge clk);
            chk_bit("no_reset_refreshed", 1'b0, system_reset_req);
        end
    endtask

    // Divisor code 1 doubles every step: ((RL + 1) * 2 * 8 + 6) periods
    task automatic t_timeout;
        int n;
        int exp;
        n = 0;
        exp = ((RL + 1) * 2 * 8 + 6) * 8;
        apb(1'b1, KEY_ADDR, {24'h000000, KEY_UNLOCK});
        apb(1'b1, PRESC_ADDR, 32'h00000001);
        repeat (20) @(posedge clk);
        apb(1'b1, KEY_ADDR, {24'h000000, KEY_REFRESH});
        while (system_reset_req !== 1'b1 && n < 700) begin
            @(posedge clk);
            n++;
        end
        chk_bit("timeout_window", 1'b1, n >= exp - 8 && n <= exp + 16);
        apb(1'b1, KEY_ADDR, {24'h000000, KEY_REFRESH});
        repeat (50) @(posedge clk);
        chk_bit("reset_held", 1'b1, system_reset_req);
    endtask

    // Strap starts the count from 0xff with no key write
    task automatic t_hw_start;
        int n;
        int exp;
        n = 0;
        exp = ((255 + 1) * 2 * 4 + 6) * 8;
        do_reset(1'b1);
        chk_bit("reset_cleared", 1'b0, system_reset_req);
        while (system_reset_req !== 1'b1 && n < 17000) begin
            @(posedge clk);
            n++;
        end
        chk_bit("hw_timeout_window", 1'b1, n >= exp - 8 && n <= exp + 40);
        apb(1'b0, STATUS_ADDR, 32'h00000000);
        chk_bit("fired_flag", 1'b1, rd[STATUS_FIRE_BIT]);
        do_reset(1'b0);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        do_reset(1'b0);
        t_reset_values();
        t_lock();
        t_start();
        t_refresh();
        t_timeout();
        t_hw_start();
        results();
    end

    // Whole run needs about 20000 clk; allow twice that
    initial begin
        #1000000;
        fail_count++;
        $display("BAD run_time expected finish seen hang");
        results();
    end
endmodule
